//--- prt_timer.sv
// three 8-bit reload down counters with prescalers, event input, cascade, flags and pulse output
// assumes apb master on pclk; oscillator and pin inputs already synchronous to pclk
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module prt_timer #(
  parameter int ADDR_W = 18,
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_osc,
  input wire logic high_speed_osc,
  input wire logic external_count_pin,
  output logic timer_pulse_output,
  output logic timer_pulse_oe_n,
  output logic serial_clk,
  output logic underflow_irq
);

  localparam int NT = 3;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (CNT_W != 8) begin : g_bad_width
    $error("prt_timer supports only 8-bit counters");
  end
  if (ADDR_W < 18) begin : g_bad_addr
    $error("prt_timer needs at least 18 address bits");
  end

  // ****************************************
  // registers and wires
  // ****************************************
  prt_pkg::prt_mode_type mode_q;
  prt_pkg::prt_pulse_type pulse_q;
  // per-timer state unpacked, so each timer's process alone drives its own entries
  prt_pkg::prt_ctl_type ctl_q [NT];
  logic [NT-1:0] cksel_q;
  logic [CNT_W-1:0] rld_q [NT];
  logic [CNT_W-1:0] cnt_q [NT];
  logic [CNT_W-1:0] pre_q [NT];
  logic [3:0] hold_q [NT];
  logic hold_valid_q [NT];
  logic [NT-1:0] mask_q;
  logic [NT-1:0] flag_q;
  logic port_data_q;
  logic port_hiz_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic ls_prev_q;
  logic hs_prev_q;
  logic [3:0] nr_div_q;
  logic nr_level_q;
  logic [1:0] nr_cnt_q;
  logic ev_prev_q;
  logic timer_pulse_output_q;
  logic ser_q;
  logic pin_q;
  logic oe_n_q;
  logic irq_q;

  logic [NT-1:0] pre_tick;
  logic [NT-1:0] cnt_tick;
  logic [NT-1:0] uf;
  logic [NT-1:0] flag_set;
  logic [3:0] rd_nib;
  logic rd_hit;

  // ****************************************
  // apb decode
  // ****************************************
  wire logic [15:0] idx = paddr[prt_pkg::ADDR_LSB +: 16];
  // offsets cut to the width of a timer number
  wire logic [1:0] ctl_sel = 2'(idx - prt_pkg::IDX_CTL0);
  wire logic [1:0] rld_sel = 2'((idx - prt_pkg::IDX_RLD0) >> 1);
  wire logic [1:0] cnt_sel = 2'((idx - prt_pkg::IDX_CNT0) >> 1);
  // answer is prepared in the first access cycle, pready follows one cycle later
  wire logic acc_first = psel & penable & ~pready_q;
  wire logic acc_done = psel & penable & pready_q;
  wire logic wr_en = acc_done & pwrite;
  wire logic rd_first = acc_first & ~pwrite;
  wire logic [3:0] wnib = pwdata[3:0];
  wire logic wr_mode = wr_en && idx == prt_pkg::IDX_MODE;
  wire logic wr_pulse = wr_en && idx == prt_pkg::IDX_PULSE;
  wire logic wr_cksel = wr_en && idx == prt_pkg::IDX_CKSEL;
  wire logic wr_port = wr_en && idx == prt_pkg::IDX_PORT;
  wire logic wr_mask = wr_en && idx == prt_pkg::IDX_MASK;
  wire logic wr_flag = wr_en && idx == prt_pkg::IDX_FLAG;

  // ****************************************
  // clock sources and noise rejector
  // ****************************************
  wire logic ls_tick = low_speed_osc & ~ls_prev_q;
  wire logic hs_tick = high_speed_osc & ~hs_prev_q;
  wire logic nr_fall = ls_tick && nr_div_q == prt_pkg::NR_DIV_LAST;
  // level must stay changed across two sampling falls, so short glitches never reach the counter
  wire logic ev_level = mode_q.noise_reject_enable ? nr_level_q : external_count_pin;
  // edge taken against last cycle's level; the pin is assumed already synchronous
  wire logic ev_edge = mode_q.event_edge_polarity ? (ev_level & ~ev_prev_q)
                                                  : (~ev_level & ev_prev_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
      nr_div_q <= 4'h0;
      nr_level_q <= 1'b0;
      nr_cnt_q <= 2'h0;
      ev_prev_q <= 1'b0;
    end else begin
      ls_prev_q <= low_speed_osc;
      hs_prev_q <= high_speed_osc;
      nr_div_q <= ls_tick ? nr_div_q + 4'h1 : nr_div_q;
      ev_prev_q <= ev_level;
      // sampler tracks the pin in every mode, so turning rejection on needs no warm-up
      if (external_count_pin == nr_level_q) begin
        nr_cnt_q <= 2'h0;
      end else if (nr_fall) begin
        if (nr_cnt_q == 2'(prt_pkg::NR_FALLS - 1)) begin
          nr_level_q <= external_count_pin;
          nr_cnt_q <= 2'h0;
        end else begin
          nr_cnt_q <= nr_cnt_q + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // count clock selection
  // ****************************************
  assign cnt_tick[0] = ctl_q[0].timer_run_bit & (mode_q.event_mode_bit ? ev_edge : pre_tick[0]);
  // in cascade timer 1 ignores its own run bit and prescaler
  assign cnt_tick[1] = mode_q.cascade_mode_bit ? uf[0] : pre_tick[1];
  assign cnt_tick[2] = pre_tick[2];
  assign flag_set = {uf[2], uf[1], uf[0] & ~mode_q.cascade_mode_bit};

  // ****************************************
  // per-timer prescaler, counter and readback hold
  // ****************************************
  for (genvar t = 0; t < NT; t++) begin : g_tmr
    wire logic run = ctl_q[t].timer_run_bit;
    wire logic src_tick = cksel_q[t] ? hs_tick : ls_tick;
    wire logic [1:0] ratio = ctl_q[t].prescaler_ratio_field;
    wire logic [CNT_W-1:0] dmask = (ratio == 2'h3) ? prt_pkg::DIV_MASK_256 :
                                   (ratio == 2'h2) ? prt_pkg::DIV_MASK_32 :
                                   (ratio == 2'h1) ? prt_pkg::DIV_MASK_4 : prt_pkg::DIV_MASK_1;
    wire logic wr_ctl = wr_en && idx == 16'(prt_pkg::IDX_CTL0 + t);
    wire logic wr_rlo = wr_en && idx == 16'(prt_pkg::IDX_RLD0 + 2 * t);
    wire logic wr_rhi = wr_en && idx == 16'(prt_pkg::IDX_RLD0 + 2 * t + 1);
    wire logic rd_clo = rd_first && idx == 16'(prt_pkg::IDX_CNT0 + 2 * t);
    wire logic rd_chi = rd_first && idx == 16'(prt_pkg::IDX_CNT0 + 2 * t + 1);
    wire logic strobe = wr_ctl & pwdata[1];

    assign pre_tick[t] = run & src_tick & ((pre_q[t] & dmask) == dmask);
    assign uf[t] = cnt_tick[t] && cnt_q[t] == '0;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_q[t] <= '0;
        rld_q[t] <= '0;
        cnt_q[t] <= '0;
        pre_q[t] <= '0;
        hold_q[t] <= 4'h0;
        hold_valid_q[t] <= 1'b0;
      end else begin
        if (wr_ctl) begin
          ctl_q[t] <= {wnib[3:2], wnib[0]};
        end
        if (wr_rlo) begin
          rld_q[t][3:0] <= wnib;
        end
        if (wr_rhi) begin
          rld_q[t][7:4] <= wnib;
        end
        // cleared while stopped, so a restart begins a full division period
        pre_q[t] <= !run ? '0 : (src_tick ? pre_q[t] + 8'h01 : pre_q[t]);
        // reload strobe wins over an underflow or a count in the same cycle
        if (strobe) begin
          cnt_q[t] <= rld_q[t];
        end else if (uf[t]) begin
          cnt_q[t] <= rld_q[t];
        end else if (cnt_tick[t]) begin
          cnt_q[t] <= cnt_q[t] - 8'h01;
        end
        // a high read with no low read first returns the live nibble
        if (rd_clo) begin
          hold_q[t] <= cnt_q[t][7:4];
          hold_valid_q[t] <= 1'b1;
        end else if (rd_chi) begin
          hold_valid_q[t] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_nib = 4'h0;
    rd_hit = 1'b1;
    if (idx == prt_pkg::IDX_MODE) begin
      rd_nib = mode_q;
    end else if (idx == prt_pkg::IDX_PULSE) begin
      rd_nib = {1'b0, pulse_q};
    end else if (idx == prt_pkg::IDX_CKSEL) begin
      rd_nib = {1'b0, cksel_q};
    end else if (idx >= prt_pkg::IDX_CTL0 && idx < prt_pkg::IDX_RLD0) begin
      // strobe reads as zero
      rd_nib = {ctl_q[ctl_sel].prescaler_ratio_field, 1'b0,
                ctl_q[ctl_sel].timer_run_bit};
    end else if (idx >= prt_pkg::IDX_RLD0 && idx < prt_pkg::IDX_CNT0) begin
      rd_nib = idx[0] ? rld_q[rld_sel][7:4] : rld_q[rld_sel][3:0];
    end else if (idx >= prt_pkg::IDX_CNT0 && idx < 16'(prt_pkg::IDX_CNT0 + 2 * NT)) begin
      if (!idx[0]) begin
        rd_nib = cnt_q[cnt_sel][3:0];
      end else if (hold_valid_q[cnt_sel]) begin
        rd_nib = hold_q[cnt_sel];
      end else begin
        rd_nib = cnt_q[cnt_sel][7:4];
      end
    end else if (idx == prt_pkg::IDX_PORT) begin
      rd_nib = {2'h0, port_hiz_q, port_data_q};
    end else if (idx == prt_pkg::IDX_MASK) begin
      rd_nib = {1'b0, mask_q};
    end else if (idx == prt_pkg::IDX_FLAG) begin
      rd_nib = {1'b0, flag_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ****************************************
  // shared control, flags, apb answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= prt_pkg::MODE_RST;
      pulse_q <= '0;
      cksel_q <= '0;
      mask_q <= '0;
      flag_q <= '0;
      port_data_q <= prt_pkg::PORT_DATA_RST;
      port_hiz_q <= prt_pkg::PORT_HIZ_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_mode) begin
        mode_q <= wnib;
      end
      if (wr_pulse) begin
        pulse_q <= wnib[2:0];
      end
      if (wr_cksel) begin
        cksel_q <= wnib[2:0];
      end
      if (wr_mask) begin
        mask_q <= wnib[2:0];
      end
      if (wr_port) begin
        port_data_q <= wnib[0];
        port_hiz_q <= wnib[1];
      end
      // a new underflow beats a simultaneous write-one clear
      flag_q <= flag_set | (flag_q & ~(wr_flag ? wnib[2:0] : 3'h0));
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~rd_hit;
      prdata_q <= (acc_first & ~pwrite) ? {28'h0000000, rd_nib} : 32'h0000_0000;
    end
  end

  // ****************************************
  // pulse, serial clock and interrupt
  // ****************************************
  wire logic [1:0] psel_src = pulse_q.pulse_source_select;
  wire logic sel_uf = psel_src[1] ? uf[2] : (psel_src[0] ? uf[1] : uf[0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_pulse_output_q <= 1'b0;
      ser_q <= 1'b0;
      pin_q <= 1'b1;
      oe_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      timer_pulse_output_q <= timer_pulse_output_q ^ sel_uf;
      // serial clock needs no pulse output enable, only timer 2 running
      ser_q <= ser_q ^ (uf[2] & ctl_q[2].timer_run_bit);
      // gating ignores pulse phase, so switching can cut a half period short
      pin_q <= pulse_q.pulse_output_enable ? timer_pulse_output_q : port_data_q;
      oe_n_q <= port_hiz_q;
      // request trails the flag by a cycle; the mask never holds the flag back
      irq_q <= |(flag_q & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_pulse_output = pin_q;
  assign timer_pulse_oe_n = oe_n_q;
  assign serial_clk = ser_q;
  assign underflow_irq = irq_q;

endmodule : prt_timer

//--- prt_pkg.sv
// constants, register indices and field carriers of the programmable reload timer
// assumes a 32-bit apb master; every register index is scaled by four into a byte address
package prt_pkg;

  // ****************************************
  // register indices (byte address = index * 4)
  // ****************************************
  localparam logic [15:0] IDX_MODE = 16'hffc0;
  localparam logic [15:0] IDX_PULSE = 16'hffc1;
  localparam logic [15:0] IDX_CKSEL = 16'hffc2;
  localparam logic [15:0] IDX_CTL0 = 16'hffc3;
  localparam logic [15:0] IDX_RLD0 = 16'hffc6;
  localparam logic [15:0] IDX_CNT0 = 16'hffcc;
  localparam logic [15:0] IDX_PORT = 16'hffd4;
  localparam logic [15:0] IDX_MASK = 16'hffe1;
  localparam logic [15:0] IDX_FLAG = 16'hfff1;
  localparam int ADDR_LSB = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic PORT_DATA_RST = 1'b1;
  localparam logic PORT_HIZ_RST = 1'b0;

  // ****************************************
  // prescaler division masks, ratio codes 00/01/10/11
  // ****************************************
  localparam logic [7:0] DIV_MASK_1 = 8'h00;
  localparam logic [7:0] DIV_MASK_4 = 8'h03;
  localparam logic [7:0] DIV_MASK_32 = 8'h1f;
  localparam logic [7:0] DIV_MASK_256 = 8'hff;

  // ****************************************
  // noise rejector timing
  // ****************************************
  localparam int LS_OSC_HZ = 32768;
  localparam int NR_SAMPLE_HZ = 2048;
  localparam int NR_DIV = LS_OSC_HZ / NR_SAMPLE_HZ;
  localparam logic [3:0] NR_DIV_LAST = 4'(NR_DIV - 1);
  localparam int NR_FALLS = 2;

  typedef struct packed {
    logic cascade_mode_bit;
    logic event_mode_bit;
    logic noise_reject_enable;
    logic event_edge_polarity;
  } prt_mode_type;

  typedef struct packed {
    logic [1:0] prescaler_ratio_field;
    logic timer_run_bit;
  } prt_ctl_type;

  typedef struct packed {
    logic [1:0] pulse_source_select;
    logic pulse_output_enable;
  } prt_pulse_type;

endpackage : prt_pkg

//--- prt_timer_checker.sv
// apb answer and serial clock checks for the reload timer
// assumes a bind onto prt_timer, one clock domain
`timescale 1ns/1ps
module prt_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_clk
);
  // ****
  // apb answer
  // ****
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_one_wait: assert property (s_first_access |=> s_answer)
    else $error("answer not one cycle after access");
  chk_setup_quiet: assert property (psel && !penable |-> !pready)
    else $error("answer during setup");
  chk_ready_req: assert property (pready |-> psel && penable && $past(penable))
    else $error("answer without access");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_upper_zero: assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("upper read bits set");
  chk_write_data: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  // ticks are at least two cycles apart, so the serial clock never flips twice running
  chk_serial_rate: assert property ($changed(serial_clk) |=> $stable(serial_clk))
    else $error("serial clock too fast");
endmodule : prt_timer_checker

//--- tb_top.sv
// self-checking bench for the reload timer
// assumes prt_pkg and prt_timer compiled first
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_pulse_output, timer_pulse_oe_n, serial_clk, underflow_irq;
  logic low_speed_osc = 1'b0;
  logic high_speed_osc = 1'b0;
  logic external_count_pin = 1'b0;
  logic [1:0] ph = 2'h0;
  int fail_count = 0;
  int checks_done = 0;
  int tog_p = 0;
  int tog_s = 0;
  prt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_osc(low_speed_osc), .high_speed_osc(high_speed_osc),
    .external_count_pin(external_count_pin), .timer_pulse_output(timer_pulse_output),
    .timer_pulse_oe_n(timer_pulse_oe_n), .serial_clk(serial_clk), .underflow_irq(underflow_irq));
  always #20 pclk = ~pclk;
  // fast source ticks every 2 cycles, slow one every 4
  // fast source modelled as settled from the start, so no start-up wait is due
  always @(posedge pclk) begin
    ph <= ph + 2'h1;
    high_speed_osc <= ph[0];
    low_speed_osc <= ph[1];
  end
  always @(timer_pulse_output) tog_p++;
  always @(serial_clk) tog_s++;
  task automatic cmp(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [3:0] wd, output logic [4:0] rsp);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {28'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    cmp("wait cycles", 9'h2, 9'(n));
    rsp = {pslverr, prdata[3:0]};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [3:0] d);
    logic [4:0] r;
    apb(1'b1, idx, d, r);
  endtask : wr
  task automatic rd(input string nm, input logic [15:0] idx, input logic [4:0] exp);
    logic [4:0] r;
    apb(1'b0, idx, 4'h0, r);
    cmp(nm, {4'h0, exp}, {4'h0, r});
  endtask : rd
  task automatic rdcnt(input int t, output logic [7:0] v);
    logic [4:0] lo, hi;
    apb(1'b0, prt_pkg::IDX_CNT0 + 16'(2 * t), 4'h0, lo);
    apb(1'b0, prt_pkg::IDX_CNT0 + 16'(2 * t + 1), 4'h0, hi);
    v = {hi[3:0], lo[3:0]};
  endtask : rdcnt
  task automatic load(input int t, input logic [7:0] v);
    wr(prt_pkg::IDX_RLD0 + 16'(2 * t), v[3:0]);
    wr(prt_pkg::IDX_RLD0 + 16'(2 * t + 1), v[7:4]);
    wr(prt_pkg::IDX_CTL0 + 16'(t), 4'h2);
  endtask : load
  task automatic t_reset;
    rd("mode", prt_pkg::IDX_MODE, 5'h00);
    rd("port", prt_pkg::IDX_PORT, 5'h01);
    rd("unmapped", 16'hffdf, 5'h10);
    cmp("pin idle", 9'h1, {8'h0, timer_pulse_output});
    cmp("pin driven", 9'h0, {8'h0, timer_pulse_oe_n});
    $display("test reset done");
  endtask : t_reset
  task automatic t_reload;
    logic [7:0] a, b;
    load(1, 8'ha5);
    rdcnt(1, a);
    cmp("loaded", {1'b0, 8'ha5}, {1'b0, a});
    wr(prt_pkg::IDX_CTL0 + 16'h1, 4'h1);
    repeat (40) @(posedge pclk);
    wr(prt_pkg::IDX_CTL0 + 16'h1, 4'h0);
    rdcnt(1, a);
    repeat (40) @(posedge pclk);
    rdcnt(1, b);
    cmp("held", {1'b0, a}, {1'b0, b});
    cmp("counted", 9'h1, {8'h0, a < 8'ha5});
    $display("test reload done");
  endtask : t_reload
  task automatic t_latch;
    logic [4:0] lo, hi, lv;
    logic [7:0] f;
    load(0, 8'hff);
    wr(prt_pkg::IDX_CTL0, 4'h1);
    repeat (8) @(posedge pclk);
    apb(1'b0, prt_pkg::IDX_CNT0, 4'h0, lo);
    repeat (200) @(posedge pclk);
    apb(1'b0, prt_pkg::IDX_CNT0 + 16'h1, 4'h0, hi);
    wr(prt_pkg::IDX_CTL0, 4'h0);
    // a high read alone must see the live count once the latch has let go
    apb(1'b0, prt_pkg::IDX_CNT0 + 16'h1, 4'h0, lv);
    rdcnt(0, f);
    cmp("latch span", 9'h1, {8'h0, (8'({hi[3:0], lo[3:0]} - f)) inside {[8'd45:8'd60]}});
    cmp("live high", {5'h0, f[7:4]}, {5'h0, lv[3:0]});
    $display("test latch done");
  endtask : t_latch
  task automatic t_prescale;
    int dv[5] = '{1, 4, 32, 256, 1};
    logic [7:0] v, e;
    for (int k = 0; k < 5; k++) begin
      e = 8'(((k == 4) ? 64 : 32) / dv[k]);
      wr(prt_pkg::IDX_CKSEL, {1'b0, k == 4, 2'h0});
      load(2, 8'hff);
      wr(prt_pkg::IDX_CTL0 + 16'h2, {2'(k), 2'h1});
      repeat (128) @(posedge pclk);
      wr(prt_pkg::IDX_CTL0 + 16'h2, {2'(k), 2'h0});
      rdcnt(2, v);
      cmp("ticks", 9'h1, {8'h0, (8'(8'hff - v)) inside {[e:e + 8'd4]}});
    end
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_event;
    logic [7:0] v;
    for (int p = 0; p < 2; p++) begin
      external_count_pin <= ~p[0];
      wr(prt_pkg::IDX_MODE, {3'b010, p[0]});
      load(0, 8'h05);
      wr(prt_pkg::IDX_CTL0, 4'hd); // slowest ratio, must be ignored
      repeat (5) begin
        repeat (4) @(posedge pclk);
        external_count_pin <= ~external_count_pin;
      end
      repeat (4) @(posedge pclk);
      wr(prt_pkg::IDX_CTL0, 4'hc);
      rdcnt(0, v);
      cmp("events", 9'h2, {1'b0, v});
    end
    wr(prt_pkg::IDX_MODE, 4'h0);
    $display("test event done");
  endtask : t_event
  task automatic t_noise;
    logic [7:0] v;
    external_count_pin <= 1'b0;
    wr(prt_pkg::IDX_MODE, 4'h7);
    load(0, 8'h05);
    repeat (200) @(posedge pclk);
    wr(prt_pkg::IDX_CTL0, 4'h1);
    // shorter than one sampling period: never seen at two sampling falls
    external_count_pin <= 1'b1;
    repeat (40) @(posedge pclk);
    external_count_pin <= 1'b0;
    repeat (200) @(posedge pclk);
    rdcnt(0, v);
    cmp("glitch rejected", 9'h5, {1'b0, v});
    external_count_pin <= 1'b1;
    repeat (200) @(posedge pclk);
    external_count_pin <= 1'b0;
    repeat (200) @(posedge pclk);
    wr(prt_pkg::IDX_CTL0, 4'h0);
    rdcnt(0, v);
    cmp("wide pulse", 9'h4, {1'b0, v});
    wr(prt_pkg::IDX_MODE, 4'h0);
    $display("test noise done");
  endtask : t_noise
  task automatic t_pulse;
    int s, q;
    wr(prt_pkg::IDX_CKSEL, 4'h0);
    load(2, 8'h00); // fastest rate, slow source flips the serial clock every 4 cycles
    wr(prt_pkg::IDX_CTL0 + 16'h2, 4'h1);
    wr(prt_pkg::IDX_PULSE, 4'h7);
    s = tog_s;
    q = tog_p;
    repeat (80) @(posedge pclk);
    cmp("serial toggles", 9'h1, {8'h0, (tog_s - s) inside {[19:22]}});
    cmp("pulse toggles", 9'h1, {8'h0, (tog_p - q) inside {[19:22]}});
    for (int c = 0; c < 3; c++) begin
      wr(prt_pkg::IDX_PULSE, {1'b0, 2'(c), c == 2 ? 1'b0 : 1'b1});
      // pin settles on the new selection two edges after the write
      repeat (2) @(posedge pclk);
      q = tog_p;
      s = tog_s;
      repeat (40) @(posedge pclk);
      cmp("quiet pin", 9'h0, 9'(tog_p - q));
      cmp("serial on", 9'h1, {8'h0, (tog_s - s) inside {[9:11]}});
    end
    cmp("pin high", 9'h1, {8'h0, timer_pulse_output});
    wr(prt_pkg::IDX_CTL0 + 16'h2, 4'h0);
    // a last underflow may still flip the serial clock on the edge that completes the write
    @(posedge pclk);
    s = tog_s;
    repeat (40) @(posedge pclk);
    cmp("serial off", 9'h0, 9'(tog_s - s));
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_cascade;
    logic [7:0] v0, v1;
    rd("flag unmasked", prt_pkg::IDX_FLAG, 5'h04);
    cmp("irq masked", 9'h0, {8'h0, underflow_irq});
    wr(prt_pkg::IDX_FLAG, 4'h7);
    wr(prt_pkg::IDX_MODE, 4'h8);
    load(0, 8'h00);
    load(1, 8'h01);
    wr(prt_pkg::IDX_CTL0, 4'h1);
    repeat (40) @(posedge pclk);
    wr(prt_pkg::IDX_CTL0, 4'h0);
    rd("cascade flags", prt_pkg::IDX_FLAG, 5'h02);
    rdcnt(0, v0);
    rdcnt(1, v1);
    cmp("cascade low", 9'h0, {1'b0, v0});
    cmp("cascade high", 9'h1, {8'h0, v1 < 8'h02});
    wr(prt_pkg::IDX_MASK, 4'h2);
    repeat (2) @(posedge pclk);
    cmp("irq on", 9'h1, {8'h0, underflow_irq});
    wr(prt_pkg::IDX_FLAG, 4'h2);
    repeat (2) @(posedge pclk);
    cmp("irq off", 9'h0, {8'h0, underflow_irq});
    $display("test cascade done");
  endtask : t_cascade
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_reload;
    t_latch;
    t_prescale;
    t_event;
    t_noise;
    t_pulse;
    t_cascade;
    close_out;
  end
  // the tests need about 2600 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    close_out;
  end
endmodule : tb_top
bind prt_timer prt_timer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_clk(serial_clk));
